//--- bench/sfrpc_assertions.sv
// checker for the page control block ports
`timescale 1ns/1ns
module sfrpc_assertions (
	// clock and reset
	input wire logic CLK_I,
	input wire logic RESET_N_I,
	// core side
	input wire logic [7:0] SFR_ADDR_I,
	input wire logic [7:0] SFR_WDATA_I,
	input wire logic SFR_WR_I,
	input wire logic SFR_RD_I,
	input wire logic ISR_ENTRY_I,
	input wire logic [7:0] ISR_PAGE_I,
	input wire logic ISR_EXIT_I,
	// answers and state
	input wire logic [7:0] SFR_RDATA_O,
	input wire logic SFR_RVALID_O,
	input wire logic [2:0] SFR_TARGET_O,
	input wire logic SFR_WE_O,
	input wire logic SFR_RE_O,
	input wire logic [7:0] PAGE_O,
	input wire logic AUTO_EN_O,
	input wire logic [2:0] STACK_IDX_O
);
	// ==========
	// helpers
	default clocking cb @(posedge CLK_I); endclocking
	default disable iff (!RESET_N_I);
	wire logic hw = (ISR_ENTRY_I || ISR_EXIT_I) && AUTO_EN_O;
	wire logic p10 = PAGE_O == 8'h10;
	wire logic [3:0] cw = {SFR_WDATA_I[6:4], SFR_WDATA_I[0]};
	// ==========
	// assertions
	a_page_write: assert property (SFR_WR_I && SFR_ADDR_I == 8'hA7 && !hw |=> PAGE_O == $past(SFR_WDATA_I))
		else $error("page write lost");
	a_select_read: assert property (SFR_RD_I && SFR_ADDR_I == 8'hA7 |=> SFR_RVALID_O && SFR_RDATA_O == $past(PAGE_O))
		else $error("page read wrong");
	a_ctl_hidden: assert property (SFR_RD_I && SFR_ADDR_I == 8'hCF && !p10 |=> !SFR_RVALID_O)
		else $error("control seen off page");
	a_timer_route: assert property ((SFR_WR_I || SFR_RD_I) && SFR_ADDR_I == 8'h98 && p10 |=> SFR_TARGET_O == 3'h6)
		else $error("timer route wrong");
	a_buffer_route: assert property (SFR_RD_I && SFR_ADDR_I == 8'h99 && (PAGE_O == 8'h00 || PAGE_O == 8'h20)
		|=> SFR_RE_O && SFR_TARGET_O == 3'h5)
		else $error("buffer route wrong");
	a_ctl_write: assert property (SFR_WR_I && SFR_ADDR_I == 8'hCF && p10 |=> {STACK_IDX_O, AUTO_EN_O} == $past(cw))
		else $error("control write wrong");
	a_isr_load: assert property (ISR_ENTRY_I && AUTO_EN_O |=> PAGE_O == $past(ISR_PAGE_I))
		else $error("entry page wrong");
	a_isr_return: assert property (ISR_ENTRY_I && AUTO_EN_O ##1 !ISR_ENTRY_I && !ISR_EXIT_I && !SFR_WR_I
		##1 ISR_EXIT_I && !ISR_ENTRY_I && AUTO_EN_O |=> PAGE_O == $past(PAGE_O, 3))
		else $error("return page wrong");
	a_paging_off: assert property ((ISR_ENTRY_I || ISR_EXIT_I) && !AUTO_EN_O && !(SFR_WR_I && SFR_ADDR_I == 8'hA7)
		|=> $stable(PAGE_O))
		else $error("page moved while off");
	// ==========
	// covers
	c_entry: cover property (ISR_ENTRY_I && AUTO_EN_O);
	c_exit_off: cover property (ISR_EXIT_I && !AUTO_EN_O);
	c_stack_read: cover property (SFR_RD_I && SFR_ADDR_I == 8'hD7 && p10);
endmodule : sfrpc_assertions

bind sfrpc_top sfrpc_assertions u_sfrpc_assertions (.CLK_I, .RESET_N_I, .SFR_ADDR_I, .SFR_WDATA_I, .SFR_WR_I,
	.SFR_RD_I, .ISR_ENTRY_I, .ISR_PAGE_I, .ISR_EXIT_I, .SFR_RDATA_O, .SFR_RVALID_O, .SFR_TARGET_O, .SFR_WE_O,
	.SFR_RE_O, .PAGE_O, .AUTO_EN_O, .STACK_IDX_O);

//--- bench/sfrpc_core_model.sv
// core model issuing register accesses and interrupt entry and exit
`timescale 1ns/1ns
module sfrpc_core_model (
	// clock
	input wire logic clk_i,
	// register access
	output logic [7:0] addr_o,
	output logic [7:0] wdata_o,
	output logic wr_o,
	output logic rd_o,
	// interrupt service
	output logic entry_o,
	output logic [7:0] isr_page_o,
	output logic exit_o
);
	// ==========
	// idle from time zero
	initial begin
		{addr_o, wdata_o, wr_o, rd_o, entry_o, isr_page_o, exit_o} = '0;
	end
	// one access held over one edge, then released with scrambled lines
	task automatic acc(input logic w, input logic r, input logic [7:0] a, input logic [7:0] d);
		@(negedge clk_i);
		addr_o = a;
		wdata_o = (a == 8'hCF) ? (d & 8'h71) : d;
		wr_o = w;
		rd_o = r;
		@(negedge clk_i);
		{wr_o, rd_o} = 2'b00;
		addr_o = ~a;
		wdata_o = ~wdata_o;
	endtask : acc
	// one interrupt entry or exit pulse
	task automatic isr(input logic en, input logic ex, input logic [7:0] p);
		@(negedge clk_i);
		entry_o = en;
		exit_o = ex;
		isr_page_o = p;
		@(negedge clk_i);
		{entry_o, exit_o} = 2'b00;
		isr_page_o = ~p;
	endtask : isr
endmodule : sfrpc_core_model

//--- bench/sfrpc_top_tb.sv
// testbench for the page control block
`timescale 1ns/1ns
module sfrpc_top_tb;
	// ==========
	// clock, reset, wiring
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic [7:0] addr, wdata, isr_page, rdata, page;
	logic wr, rd_s, entry, isr_exit, rvalid, auto_en;
	logic [2:0] target, idx;
	logic [7:0] faddr, fwdata;
	logic fwe, fre;
	int errors = 0;
	int samples_checked = 0;
	logic [7:0] qr[$];
	logic [23:0] qf[$];
	logic [7:0] p[1:5];
	always #10 clk = ~clk;
	sfrpc_top u_sfrpc_top (.CLK_I(clk), .RESET_N_I(rst_n), .SFR_ADDR_I(addr), .SFR_WDATA_I(wdata), .SFR_WR_I(wr),
		.SFR_RD_I(rd_s), .ISR_ENTRY_I(entry), .ISR_PAGE_I(isr_page), .ISR_EXIT_I(isr_exit), .SFR_RDATA_O(rdata),
		.SFR_RVALID_O(rvalid), .SFR_TARGET_O(target), .SFR_ADDR_O(faddr), .SFR_WDATA_O(fwdata), .SFR_WE_O(fwe),
		.SFR_RE_O(fre),
		.PAGE_O(page), .AUTO_EN_O(auto_en), .STACK_IDX_O(idx));
	sfrpc_core_model u_sfrpc_core_model (.clk_i(clk), .addr_o(addr), .wdata_o(wdata), .wr_o(wr), .rd_o(rd_s),
		.entry_o(entry), .isr_page_o(isr_page), .exit_o(isr_exit));
	// ==========
	// compares and verdict
	task automatic chk(input string n, input logic [7:0] e, input logic [7:0] s);
		samples_checked++;
		if (s !== e) begin
			errors++;
			$display("ERROR %s expected %h seen %h", n, e, s);
		end
	endtask : chk
	// forwarded access: target, strobes, address and data together
	task automatic chk_fwd(input string n, input logic [23:0] e, input logic [23:0] s);
		samples_checked++;
		if (s !== e) begin
			errors++;
			$display("ERROR %s expected %h seen %h", n, e, s);
		end
	endtask : chk_fwd
	task automatic stop_test();
		errors += qr.size() + qf.size();
		$display("checked %0d errors %0d", samples_checked, errors);
		if (errors == 0 && samples_checked > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask : stop_test
	// monitor takes the oldest note for each answer
	always @(negedge clk) begin
		if (rvalid !== 1'b0) chk("read data", (qr.size() > 0) ? qr.pop_front() : 8'hxx, rdata);
		if (target !== 3'h0) chk_fwd("forward", (qf.size() > 0) ? qf.pop_front() : 24'hxxxxxx, {3'h0, target, fwe, fre, faddr, fwdata});
	end
	// drivers
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		qr.push_back(e);
		u_sfrpc_core_model.acc(1'b0, 1'b1, a, 8'h00);
	endtask : rd
	task automatic wr_r(input logic [7:0] a, input logic [7:0] d);
		u_sfrpc_core_model.acc(1'b1, 1'b0, a, d);
	endtask : wr_r
	task automatic fw(input logic w, input logic [7:0] a, input logic [2:0] t);
		qf.push_back({3'h0, t, w, !w, a, 8'h5A});
		u_sfrpc_core_model.acc(w, !w, a, 8'h5A);
	endtask : fw
	// ==========
	// tests
	initial begin
		repeat (10) @(posedge clk);
		@(negedge clk) rst_n = 1'b1;
		void'($urandom(32'hB8019314));
		rd(8'hA7, 8'h00);
		wr_r(8'hA7, 8'h10);
		rd(8'hCF, 8'h01);
		rd(8'hD7, 8'h10);
		fw(1'b1, 8'h98, 3'h6);
		$display("test reset done");
		for (int i = 0; i < 2; i++) begin
			wr_r(8'hA7, i ? 8'h20 : 8'h00);
			rd(8'hA7, i ? 8'h20 : 8'h00);
			fw(1'b0, 8'h98, 3'h4);
			fw(1'b1, 8'h99, 3'h5);
			u_sfrpc_core_model.acc(1'b0, 1'b1, 8'hCF, 8'h00);
		end
		$display("test decode done");
		wr_r(8'hA7, 8'h10);
		for (int i = 1; i <= 5; i++) begin
			p[i] = 8'($urandom());
			u_sfrpc_core_model.isr(1'b1, 1'b0, p[i]);
		end
		rd(8'hA7, p[5]);
		wr_r(8'hA7, 8'h10);
		for (int i = 1; i <= 5; i++) begin
			wr_r(8'hCF, 8'h01 | 8'(i << 4));
			rd(8'hD7, (i == 5) ? 8'h00 : p[5 - i]);
		end
		u_sfrpc_core_model.isr(1'b0, 1'b1, 8'h00);
		rd(8'hA7, p[4]);
		repeat (4) u_sfrpc_core_model.isr(1'b0, 1'b1, 8'h00);
		rd(8'hA7, p[1]);
		u_sfrpc_core_model.isr(1'b1, 1'b0, 8'h3C);
		u_sfrpc_core_model.isr(1'b0, 1'b1, 8'h00);
		rd(8'hA7, p[1]);
		$display("test stack done");
		wr_r(8'hA7, 8'h10);
		wr_r(8'hCF, 8'h00);
		rd(8'hCF, 8'h00);
		u_sfrpc_core_model.isr(1'b1, 1'b0, 8'h55);
		rd(8'hA7, 8'h10);
		u_sfrpc_core_model.isr(1'b0, 1'b1, 8'h00);
		rd(8'hA7, 8'h10);
		$display("test paging off done");
		for (int i = 0; i < 8 && qr.size() + qf.size() > 0; i++) @(negedge clk);
		stop_test();
	end
	// hang guard
	initial begin
		repeat (20000) @(posedge clk);
		errors++;
		stop_test();
	end
endmodule : sfrpc_top_tb

//--- logic/sfrpc_decode.sv
// paged address decoder for special function registers
`timescale 1ns/1ns
module sfrpc_decode (
	// access address and current page
	input wire logic [7:0] addr_i,
	input wire logic [7:0] page_i,
	// resolved target
	output sfrpc_pkg::sfrpc_target_e target_o
);

	// ==========================================================
	// page qualifiers
	logic on_p00;
	logic on_p10;
	logic on_p20;

	assign on_p00 = (page_i == sfrpc_pkg::PAGE_00);
	assign on_p10 = (page_i == sfrpc_pkg::PAGE_10);
	assign on_p20 = (page_i == sfrpc_pkg::PAGE_20);

	// ==========================================================
	// one address resolves per page
	always_comb begin
		target_o = sfrpc_pkg::TGT_NONE;
		if (addr_i == sfrpc_pkg::ADDR_PAGE_SELECT) begin
			target_o = sfrpc_pkg::TGT_PAGE_SELECT;
		end else if (on_p10 && addr_i == sfrpc_pkg::ADDR_PAGE_CONTROL) begin
			target_o = sfrpc_pkg::TGT_PAGE_CONTROL;
		end else if (on_p10 && addr_i == sfrpc_pkg::ADDR_STACK_READBACK) begin
			target_o = sfrpc_pkg::TGT_STACK_READBACK;
		end else if (on_p10 && addr_i == sfrpc_pkg::ADDR_TIMER_FOUR_CONTROL) begin
			target_o = sfrpc_pkg::TGT_TIMER_FOUR_CONTROL;
		end else if ((on_p00 || on_p20) && addr_i == sfrpc_pkg::ADDR_SERIAL_ZERO_CONTROL) begin
			target_o = sfrpc_pkg::TGT_SERIAL_ZERO_CONTROL;
		end else if ((on_p00 || on_p20) && addr_i == sfrpc_pkg::ADDR_SERIAL_ZERO_BUFFER) begin
			target_o = sfrpc_pkg::TGT_SERIAL_ZERO_BUFFER;
		end
	end

endmodule : sfrpc_decode

//--- logic/sfrpc_pkg.sv
// constants and types shared by the page control block
package sfrpc_pkg;

	// ==========================================================
	// bus and field widths, stack depth
	localparam int unsigned DATA_W = 8;
	localparam int unsigned IDX_W = 3;
	localparam int unsigned DEEP_LEVELS = 4;

	// ==========================================================
	// register addresses
	localparam logic [7:0] ADDR_PAGE_SELECT = 8'hA7;
	localparam logic [7:0] ADDR_PAGE_CONTROL = 8'hCF;
	localparam logic [7:0] ADDR_STACK_READBACK = 8'hD7;
	localparam logic [7:0] ADDR_SERIAL_ZERO_CONTROL = 8'h98;
	localparam logic [7:0] ADDR_SERIAL_ZERO_BUFFER = 8'h99;
	localparam logic [7:0] ADDR_TIMER_FOUR_CONTROL = 8'h98;

	// ==========================================================
	// page numbers
	localparam logic [7:0] PAGE_00 = 8'h00;
	localparam logic [7:0] PAGE_10 = 8'h10;
	localparam logic [7:0] PAGE_20 = 8'h20;

	// ==========================================================
	// page control field positions
	localparam int unsigned CTL_EN_BIT = 0;
	localparam int unsigned CTL_IDX_LSB = 4;
	localparam int unsigned CTL_IDX_MSB = 6;

	// ==========================================================
	// values after reset
	localparam logic [7:0] RST_PAGE_SELECT = 8'h00;
	localparam logic [2:0] RST_STACK_IDX = 3'h0;
	localparam logic RST_AUTO_EN = 1'b1;
	localparam logic [7:0] RST_STACK_LEVEL = 8'h00;
	localparam logic [7:0] RST_RDATA = 8'h00;

	// ==========================================================
	// decoded register targets
	typedef enum logic [2:0] {
		TGT_NONE = 3'h0,
		TGT_PAGE_SELECT = 3'h1,
		TGT_PAGE_CONTROL = 3'h2,
		TGT_STACK_READBACK = 3'h3,
		TGT_SERIAL_ZERO_CONTROL = 3'h4,
		TGT_SERIAL_ZERO_BUFFER = 3'h5,
		TGT_TIMER_FOUR_CONTROL = 3'h6
	} sfrpc_target_e;

endpackage : sfrpc_pkg

//--- logic/sfrpc_stack.sv
// deeper levels of the page stack, below the live page
`timescale 1ns/1ns
module sfrpc_stack (
	// clock and reset
	input wire logic clk_i,
	input wire logic reset_n_i,
	// push and pop
	input wire logic push_i,
	input wire logic pop_i,
	input wire logic [7:0] top_i,
	// readback
	input wire logic [2:0] idx_i,
	output logic [7:0] pop_val_o,
	output logic [7:0] read_o
);

	// ==========================================================
	// levels two to five
	logic [7:0] lvl_q [sfrpc_pkg::DEEP_LEVELS];
	logic [7:0] lvl_d [sfrpc_pkg::DEEP_LEVELS];

	// shift deeper on push, shallower on pop
	always_comb begin
		for (int i = 0; i < sfrpc_pkg::DEEP_LEVELS; i++) begin
			lvl_d[i] = lvl_q[i];
		end
		if (push_i) begin
			lvl_d[0] = top_i;
			for (int i = 1; i < sfrpc_pkg::DEEP_LEVELS; i++) begin
				lvl_d[i] = lvl_q[i - 1];
			end
		end else if (pop_i) begin
			for (int i = 0; i < sfrpc_pkg::DEEP_LEVELS - 1; i++) begin
				lvl_d[i] = lvl_q[i + 1];
			end
		end
	end

	// level storage
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			for (int i = 0; i < sfrpc_pkg::DEEP_LEVELS; i++) begin
				lvl_q[i] <= sfrpc_pkg::RST_STACK_LEVEL;
			end
		end else begin
			for (int i = 0; i < sfrpc_pkg::DEEP_LEVELS; i++) begin
				lvl_q[i] <= lvl_d[i];
			end
		end
	end

	// ==========================================================
	// outputs
	assign pop_val_o = lvl_q[0];

	// index zero reads the live page
	always_comb begin
		case (idx_i)
			3'h0: read_o = top_i;
			3'h1: read_o = lvl_q[0];
			3'h2: read_o = lvl_q[1];
			3'h3: read_o = lvl_q[2];
			3'h4: read_o = lvl_q[3];
			default: read_o = 8'h00;
		endcase
	end

endmodule : sfrpc_stack

//--- logic/sfrpc_top.sv
// special function register page control: page select, auto paging, page stack
//
// Behaviour
// - eight-bit page select register, reset zero, picks page for every access.
// - page select answers at 0xA7 on every page.
// - page control answers at 0xCF only on page 0x10.
// - same address reaches different registers depending on selected page.
// - register listed on several pages answers on each of them.
// - stack index bits 6:4, reset zero; zero reads the live page.
// - index one to four read stack levels two to five.
// - enable bit 0, reset one, pushes live page on interrupt entry.
// - enabled entry loads page select with the interrupting flag's page.
// - enabled return pops the stack back into page select.
// - disabled paging leaves stack and page select alone on entry and exit.
// - read-only stack readback at 0xD7 on page 0x10 shows indexed level.
`timescale 1ns/1ns
module sfrpc_top (
	// clock and reset
	input wire logic CLK_I,
	input wire logic RESET_N_I,
	// register access from the core
	input wire logic [7:0] SFR_ADDR_I,
	input wire logic [7:0] SFR_WDATA_I,
	input wire logic SFR_WR_I,
	input wire logic SFR_RD_I,
	// interrupt service entry and exit
	input wire logic ISR_ENTRY_I,
	input wire logic [7:0] ISR_PAGE_I,
	input wire logic ISR_EXIT_I,
	// read answer for own registers
	output logic [7:0] SFR_RDATA_O,
	output logic SFR_RVALID_O,
	// decoded access towards peripherals
	output logic [2:0] SFR_TARGET_O,
	output logic [7:0] SFR_ADDR_O,
	output logic [7:0] SFR_WDATA_O,
	output logic SFR_WE_O,
	output logic SFR_RE_O,
	// page state
	output logic [7:0] PAGE_O,
	output logic AUTO_EN_O,
	output logic [2:0] STACK_IDX_O
);

	// ==========================================================
	// decode of the current access
	sfrpc_pkg::sfrpc_target_e target;
	logic own_wr;
	logic own_rd;
	logic wr_page_select;
	logic wr_page_control;

	// ==========================================================
	// page state registers
	logic [7:0] page_q;
	logic [7:0] page_d;
	logic auto_en_q;
	logic auto_en_d;
	logic [2:0] idx_q;
	logic [2:0] idx_d;

	// ==========================================================
	// stack handshake
	logic push;
	logic pop;
	logic [7:0] pop_val;
	logic [7:0] stack_read;

	// ==========================================================
	// answer and forwarded access registers
	logic [7:0] rdata_q;
	logic [7:0] rdata_d;
	logic rvalid_q;
	logic rvalid_d;
	logic [2:0] tgt_q;
	logic [2:0] tgt_d;
	logic [7:0] addr_q;
	logic [7:0] addr_d;
	logic [7:0] wdata_q;
	logic [7:0] wdata_d;
	logic we_q;
	logic we_d;
	logic re_q;
	logic re_d;

	// ==========================================================
	// address decoder, steered by the live page
	sfrpc_decode u_decode (
		.addr_i(SFR_ADDR_I),
		.page_i(page_q),
		.target_o(target)
	);

	// own register strobes
	assign own_wr = SFR_WR_I;
	assign own_rd = SFR_RD_I;
	assign wr_page_select = own_wr && (target == sfrpc_pkg::TGT_PAGE_SELECT);
	assign wr_page_control = own_wr && (target == sfrpc_pkg::TGT_PAGE_CONTROL);

	// ==========================================================
	// interrupt paging: entry wins over a same-cycle exit
	assign push = auto_en_q && ISR_ENTRY_I;
	assign pop = auto_en_q && ISR_EXIT_I && !ISR_ENTRY_I;

	// ==========================================================
	// page stack below the live page
	sfrpc_stack u_stack (
		.clk_i(CLK_I),
		.reset_n_i(RESET_N_I),
		.push_i(push),
		.pop_i(pop),
		.top_i(page_q),
		.idx_i(idx_q),
		.pop_val_o(pop_val),
		.read_o(stack_read)
	);

	// ==========================================================
	// next page select: hardware paging beats a software write
	always_comb begin
		page_d = page_q;
		if (push) begin
			page_d = ISR_PAGE_I;
		end else if (pop) begin
			page_d = pop_val;
		end else if (wr_page_select) begin
			page_d = SFR_WDATA_I;
		end
	end

	// next page control fields, reserved bits not stored
	always_comb begin
		auto_en_d = auto_en_q;
		idx_d = idx_q;
		if (wr_page_control) begin
			auto_en_d = SFR_WDATA_I[sfrpc_pkg::CTL_EN_BIT];
			idx_d = SFR_WDATA_I[sfrpc_pkg::CTL_IDX_MSB:sfrpc_pkg::CTL_IDX_LSB];
		end
	end

	// page state storage
	always_ff @(posedge CLK_I or negedge RESET_N_I) begin
		if (!RESET_N_I) begin
			page_q <= sfrpc_pkg::RST_PAGE_SELECT;
			auto_en_q <= sfrpc_pkg::RST_AUTO_EN;
			idx_q <= sfrpc_pkg::RST_STACK_IDX;
		end else begin
			page_q <= page_d;
			auto_en_q <= auto_en_d;
			idx_q <= idx_d;
		end
	end

	// ==========================================================
	// read answer for the three own registers
	always_comb begin
		rdata_d = sfrpc_pkg::RST_RDATA;
		rvalid_d = 1'b0;
		if (own_rd) begin
			case (target)
				sfrpc_pkg::TGT_PAGE_SELECT: begin
					rdata_d = page_q;
					rvalid_d = 1'b1;
				end
				sfrpc_pkg::TGT_PAGE_CONTROL: begin
					rdata_d[sfrpc_pkg::CTL_EN_BIT] = auto_en_q;
					rdata_d[sfrpc_pkg::CTL_IDX_MSB:sfrpc_pkg::CTL_IDX_LSB] = idx_q;
					rvalid_d = 1'b1;
				end
				sfrpc_pkg::TGT_STACK_READBACK: begin
					rdata_d = stack_read;
					rvalid_d = 1'b1;
				end
				default: begin
					rdata_d = sfrpc_pkg::RST_RDATA;
					rvalid_d = 1'b0;
				end
			endcase
		end
	end

	// ==========================================================
	// forward decoded peripheral accesses one cycle later
	always_comb begin
		tgt_d = 3'h0;
		addr_d = 8'h00;
		wdata_d = 8'h00;
		we_d = 1'b0;
		re_d = 1'b0;
		case (target)
			sfrpc_pkg::TGT_SERIAL_ZERO_CONTROL,
			sfrpc_pkg::TGT_SERIAL_ZERO_BUFFER,
			sfrpc_pkg::TGT_TIMER_FOUR_CONTROL: begin
				if (SFR_WR_I || SFR_RD_I) begin
					tgt_d = target;
					addr_d = SFR_ADDR_I;
					wdata_d = SFR_WDATA_I;
					we_d = SFR_WR_I;
					re_d = SFR_RD_I;
				end
			end
			default: begin
				tgt_d = 3'h0;
			end
		endcase
	end

	// answer and forwarding storage
	always_ff @(posedge CLK_I or negedge RESET_N_I) begin
		if (!RESET_N_I) begin
			rdata_q <= sfrpc_pkg::RST_RDATA;
			rvalid_q <= 1'b0;
			tgt_q <= 3'h0;
			addr_q <= 8'h00;
			wdata_q <= 8'h00;
			we_q <= 1'b0;
			re_q <= 1'b0;
		end else begin
			rdata_q <= rdata_d;
			rvalid_q <= rvalid_d;
			tgt_q <= tgt_d;
			addr_q <= addr_d;
			wdata_q <= wdata_d;
			we_q <= we_d;
			re_q <= re_d;
		end
	end

	// ==========================================================
	// outputs, all from flops
	assign SFR_RDATA_O = rdata_q;
	assign SFR_RVALID_O = rvalid_q;
	assign SFR_TARGET_O = tgt_q;
	assign SFR_ADDR_O = addr_q;
	assign SFR_WDATA_O = wdata_q;
	assign SFR_WE_O = we_q;
	assign SFR_RE_O = re_q;
	assign PAGE_O = page_q;
	assign AUTO_EN_O = auto_en_q;
	assign STACK_IDX_O = idx_q;

endmodule : sfrpc_top
